// >>> hw/wpc_pkg.sv
// constants shared by the write path control block
package wpc_pkg;

	// clock and bit cell timing, in picoseconds
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CELL_PS_5M0   = 200000;
	localparam int CELL_PS_4M84  = 206600;

	// write current converter code limits and stepping
	localparam logic [6:0] WC_CODE_MIN   = 7'h00;
	localparam logic [6:0] WC_CODE_MAX   = 7'h53;
	localparam int         WC_STEP_SHIFT = 3;

	// register bus geometry
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int CYL_W  = 10;

	// register byte offsets
	localparam logic [ADDR_W-1:0] REG_CYL    = 5'h00;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h08;
	localparam logic [ADDR_W-1:0] REG_WCODE  = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_RDCNT  = 5'h10;
	localparam logic [ADDR_W-1:0] REG_WRCNT  = 5'h14;

	// control register fields
	localparam int CTRL_CLR_BIT     = 0;
	localparam int CTRL_INHIBIT_BIT = 1;

	// status register fields
	localparam int STAT_UNSAFE_BIT = 0;
	localparam int STAT_WMODE_BIT  = 1;
	localparam int STAT_WCUR_BIT   = 2;
	localparam int STAT_RAW_BIT    = 3;

	// reset values
	localparam logic [CYL_W-1:0] CYL_RESET  = 10'h000;
	localparam logic [15:0]      CNT_RESET  = 16'h0000;
	localparam logic [2:0]       HEAD_RESET = 3'h0;

	// encoder states
	typedef enum logic [1:0] {
		ENC_IDLE = 2'b00,
		ENC_RUN  = 2'b01
	} enc_state_t;

endpackage

// >>> hw/flux_resolver.sv
// one resolving flip-flop of the read qualifier
`timescale 1ns/1ps
`default_nettype none

module flux_resolver #(
	parameter logic EDGE_LEVEL = 1'b1
) (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic hi_res,
	input  wire logic lo_res,
	input  wire logic blank,
	output logic      hit
);

	logic hi_prev_reg;
	logic hit_reg;

	// last high resolution level; follows the pin through reset
	// so a comparator idling high gives no false edge after reset
	always_ff @(posedge mclk) begin
		hi_prev_reg <= hi_res;
	end

	// high res edge clocks, low res level enables [R12]
	// a lone high res wiggle without low res agreement is dropped
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			hit_reg <= 1'b0;
		end else begin
			hit_reg <= !blank && (hi_res == EDGE_LEVEL) && (hi_prev_reg != EDGE_LEVEL)
				&& (lo_res == EDGE_LEVEL);
		end
	end

	assign hit = hit_reg;

endmodule // flux_resolver

`default_nettype wire

// >>> hw/write_path_control.sv
// write path control: cell encoder, write gating, unsafe latch, read qualifier
//
// Functional notes
// [R1] innermost tracks load write current code zero
// [R2] outermost tracks load write current code 83
// [R3] code follows cylinder, steps every eight tracks
// [R4] capture write data only while gate asserted
// [R5] write data leaves as true/inverted pair
// [R6] write select output is active low
// [R7] select inactive keeps preamp in read mode
// [R8] write data driver disconnected when not writing
// [R9] unsafe indication kills write current immediately
// [R10] preamp unsafe report sets sticky latch
// [R11] latch holds select, current, enable off
// [R12] high res clocks, low res enables resolvers
// [R13] resolver outputs ORed into one pulse
// [R14] qualified pulses go to decoding logic
// [R15] read clamp asserted throughout write mode
// [R16] 5.0 Mbit/s variant: 200 ns cells
// [R17] data one: transition at mid cell
// [R18] zero: end-of-cell transition unless next one
// [R19] no forced boundary transitions; 1 to 0.5/bit
// [R20] 4.84 Mbit/s variant: 206.6 ns cells; the code truncates to 51 clocks, 204 ns
// [R21] controller holds write enable low whole write
// [R22] head selection settled before writing enabled
// [R23] simultaneous unsafe and clear leaves latch set
// [R24] reset clears latch, select inactive
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module write_path_control
	import wpc_pkg::*;
#(
	parameter int RATE_SEL = 0
) (
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              write_enable_n,
	input  wire logic              wr_bit,
	input  wire logic              wr_bit_valid,
	input  wire logic [2:0]        head_sel,
	input  wire logic              unsafe_n,
	input  wire logic              unsafe_clear,
	input  wire logic              hi_res_cmp,
	input  wire logic              lo_res_cmp,
	output logic                   write_select_n,
	output logic                   wd_true,
	output logic                   wd_inv,
	output logic                   wd_drive_en,
	output logic                   wcur_en,
	output logic      [6:0]        wcur_code,
	output logic      [2:0]        head_out,
	output logic                   read_clamp,
	output logic                   read_pulse,
	output logic                   unsafe_out
);

	// cell timing, derived from the printed cell widths
	localparam int CELL_PS  = (RATE_SEL == 0) ? CELL_PS_5M0 : CELL_PS_4M84; // [R16] [R20]
	localparam int CELL_CYC = CELL_PS / CLK_PERIOD_PS;
	localparam int HALF_CYC = CELL_CYC / 2;
	localparam logic [7:0] CELL_LAST = 8'(CELL_CYC - 1);
	localparam logic [7:0] CELL_HALF = 8'(HALF_CYC);

	// refuse variants the cell counter cannot serve
	generate
		if (RATE_SEL < 0 || RATE_SEL > 1) begin : g_bad_rate
			$error("RATE_SEL must be 0 or 1");
		end
		if (CELL_CYC < 2 || CELL_CYC > 255) begin : g_bad_cell
			$error("cell length out of counter range");
		end
	endgenerate

	// software state
	logic [CYL_W-1:0]  cyl_reg;
	logic              inhibit_reg;
	logic              clr_pulse_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [15:0]       rd_cnt_reg;
	logic [15:0]       wr_cnt_reg;

	// write side state
	logic        unsafe_latch_reg;
	logic        wmode_reg;
	logic        wsel_n_reg;
	logic        wcur_en_reg;
	logic [6:0]  wcode_reg;
	logic [6:0]  wcode_next;
	logic [2:0]  head_reg;
	logic        data_ff_reg;
	logic        cur_bit_reg;
	logic        flux_reg;
	logic        flux_inv_reg;
	logic        drive_en_reg;
	logic        clamp_reg;
	logic [7:0]  cell_cnt_reg;
	enc_state_t  enc_state_reg;

	// read side
	logic        hit_rise;
	logic        hit_fall;
	logic        rpulse_reg;

	// unsafe and write request, combinational view of the pins
	logic        unsafe_now;
	logic        gate_req;
	logic        write_ok;
	logic [CYL_W-WC_STEP_SHIFT-1:0] cyl_group;

	assign unsafe_now = !unsafe_n;
	assign gate_req   = !write_enable_n; // [R21]
	assign write_ok   = gate_req && !inhibit_reg && !unsafe_latch_reg && !unsafe_now; // [R11]
	assign cyl_group  = cyl_reg[CYL_W-1:WC_STEP_SHIFT];

	// register writes; the clear bit is a self-clearing pulse
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cyl_reg       <= CYL_RESET;
			inhibit_reg   <= 1'b0;
			clr_pulse_reg <= 1'b0;
		end else begin
			clr_pulse_reg <= 1'b0;
			if (reg_wr && reg_addr == REG_CYL) begin
				cyl_reg <= reg_wdata[CYL_W-1:0];
			end
			if (reg_wr && reg_addr == REG_CTRL) begin
				inhibit_reg   <= reg_wdata[CTRL_INHIBIT_BIT];
				clr_pulse_reg <= reg_wdata[CTRL_CLR_BIT];
			end
		end
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdata_reg <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CYL: begin
					rdata_reg <= {{(DATA_W-CYL_W){1'b0}}, cyl_reg};
				end
				REG_CTRL: begin
					rdata_reg <= {{(DATA_W-2){1'b0}}, inhibit_reg, 1'b0};
				end
				REG_STATUS: begin
					rdata_reg <= {{(DATA_W-4){1'b0}}, unsafe_now, wcur_en_reg,
						wmode_reg, unsafe_latch_reg};
				end
				REG_WCODE: begin
					rdata_reg <= {{(DATA_W-7){1'b0}}, wcode_reg};
				end
				REG_RDCNT: begin
					rdata_reg <= {{(DATA_W-16){1'b0}}, rd_cnt_reg};
				end
				REG_WRCNT: begin
					rdata_reg <= {{(DATA_W-16){1'b0}}, wr_cnt_reg};
				end
				default: begin
					rdata_reg <= '0; // unmapped reads as zero
				end
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end

	// write current code from cylinder: cylinder 0 is the outer edge
	// saturates so any cylinder past the last group still gets minimum
	always_comb begin
		if (cyl_group >= (CYL_W-WC_STEP_SHIFT)'(WC_CODE_MAX)) begin
			wcode_next = WC_CODE_MIN; // [R1]
		end else begin
			wcode_next = WC_CODE_MAX - cyl_group[6:0]; // [R2] [R3]
		end
	end

	// registered so the converter never sees a half-updated code
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wcode_reg <= WC_CODE_MIN;
		end else begin
			wcode_reg <= wcode_next; // [R3]
		end
	end

	// sticky unsafe latch; a new fault beats a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			unsafe_latch_reg <= 1'b0; // [R24]
		end else if (unsafe_now) begin
			unsafe_latch_reg <= 1'b1; // [R10] [R23]
		end else if (unsafe_clear || clr_pulse_reg) begin
			unsafe_latch_reg <= 1'b0; // [R11]
		end
	end

	// write current level: dropped on the first cycle of unsafe
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wcur_en_reg <= 1'b0;
		end else begin
			wcur_en_reg <= write_ok; // [R9] [R11]
		end
	end

	// write mode, select and clamp move together
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wmode_reg  <= 1'b0;
			wsel_n_reg <= 1'b1; // [R24]
			clamp_reg  <= 1'b0;
		end else begin
			wmode_reg  <= write_ok;
			wsel_n_reg <= !write_ok; // [R6] [R7] [R11]
			clamp_reg  <= write_ok;  // [R15]
		end
	end

	// head is frozen for the whole write so the preamp never switches mid-write
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			head_reg <= HEAD_RESET;
		end else if (!gate_req && !wmode_reg) begin
			head_reg <= head_sel; // [R22]
		end
	end

	// incoming write data bit, taken only under the gate
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			data_ff_reg <= 1'b0;
		end else if (gate_req && wr_bit_valid) begin
			data_ff_reg <= wr_bit; // [R4]
		end
	end

	// cell encoder: one cell per CELL_CYC clocks while writing
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			enc_state_reg <= ENC_IDLE;
			cell_cnt_reg  <= 8'h00;
			cur_bit_reg   <= 1'b1;
			flux_reg      <= 1'b0;
			flux_inv_reg  <= 1'b1;
		end else begin
			case (enc_state_reg)
				ENC_IDLE: begin
					cell_cnt_reg <= 8'h00;
					cur_bit_reg  <= 1'b1; // no boundary flip on the first cell
					if (write_ok) begin
						enc_state_reg <= ENC_RUN;
					end
				end
				ENC_RUN: begin
					if (!write_ok) begin
						enc_state_reg <= ENC_IDLE;
					end else if (cell_cnt_reg == 8'h00) begin
						// boundary: flip only between two zeros [R18] [R19]
						if (!cur_bit_reg && !data_ff_reg) begin
							flux_reg     <= !flux_reg;
							flux_inv_reg <= !flux_inv_reg; // [R5]
						end
						cur_bit_reg  <= data_ff_reg;
						cell_cnt_reg <= cell_cnt_reg + 8'h01;
					end else begin
						// mid cell: a one flips the flux [R17]
						if (cell_cnt_reg == CELL_HALF && cur_bit_reg) begin
							flux_reg     <= !flux_reg;
							flux_inv_reg <= !flux_inv_reg; // [R5]
						end
						if (cell_cnt_reg == CELL_LAST) begin
							cell_cnt_reg <= 8'h00;
						end else begin
							cell_cnt_reg <= cell_cnt_reg + 8'h01;
						end
					end
				end
				default: begin
					enc_state_reg <= ENC_IDLE;
				end
			endcase
		end
	end

	// differential driver; disconnected outside write mode
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			drive_en_reg <= 1'b0;
		end else begin
			drive_en_reg <= write_ok && (enc_state_reg == ENC_RUN); // [R8]
		end
	end

	// cells written, wraps; a cheap activity check for software
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wr_cnt_reg <= CNT_RESET;
		end else if (enc_state_reg == ENC_RUN && write_ok && cell_cnt_reg == 8'h00) begin
			wr_cnt_reg <= wr_cnt_reg + 16'h0001;
		end
	end

	// rising and falling flux resolvers
	flux_resolver #(
		.EDGE_LEVEL(1'b1)
	) u_res_rise (
		.mclk  (mclk),
		.resetn(resetn),
		.hi_res(hi_res_cmp),
		.lo_res(lo_res_cmp),
		.blank (clamp_reg),
		.hit   (hit_rise)
	);

	flux_resolver #(
		.EDGE_LEVEL(1'b0)
	) u_res_fall (
		.mclk  (mclk),
		.resetn(resetn),
		.hi_res(hi_res_cmp),
		.lo_res(lo_res_cmp),
		.blank (clamp_reg),
		.hit   (hit_fall)
	);

	// one pulse per qualified transition, to the decoder [R13] [R14]
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rpulse_reg <= 1'b0;
		end else begin
			rpulse_reg <= hit_rise || hit_fall; // [R13]
		end
	end

	// read pulse count, wraps
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rd_cnt_reg <= CNT_RESET;
		end else if (rpulse_reg) begin
			rd_cnt_reg <= rd_cnt_reg + 16'h0001;
		end
	end

	// outputs, all from flip-flops
	assign reg_rdata      = rdata_reg;
	assign write_select_n = wsel_n_reg;
	assign wd_true        = flux_reg; // [R5]
	assign wd_inv         = flux_inv_reg; // [R5]
	assign wd_drive_en    = drive_en_reg;
	assign wcur_en        = wcur_en_reg;
	assign wcur_code      = wcode_reg;
	assign head_out       = head_reg;
	assign read_clamp     = clamp_reg;
	assign read_pulse     = rpulse_reg; // [R14]
	assign unsafe_out     = unsafe_latch_reg;

endmodule // write_path_control

`default_nettype wire

// >>> testbench/wpc_assertions.sv
// port-level checks for the write path control block
`timescale 1ns/1ps
`default_nettype none
module wpc_checker
	import wpc_pkg::*;
(
	input wire logic              mclk,
	input wire logic              resetn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              write_enable_n,
	input wire logic              unsafe_n,
	input wire logic              hi_res_cmp,
	input wire logic              lo_res_cmp,
	input wire logic              write_select_n,
	input wire logic              wd_true,
	input wire logic              wd_inv,
	input wire logic              wd_drive_en,
	input wire logic              wcur_en,
	input wire logic [6:0]        wcur_code,
	input wire logic              read_clamp,
	input wire logic              read_pulse,
	input wire logic              unsafe_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// code from cylinder, clamped to zero on the inner tracks
	function automatic logic [6:0] code_of(input logic [9:0] c);
		return (c >= 10'h298) ? 7'h00 : WC_CODE_MAX - 7'(c >> 3);
	endfunction
	property p_code;
		reg_wr && reg_addr == REG_CYL |-> ##2 wcur_code == code_of($past(reg_wdata[9:0], 2));
	endproperty
	a_code: assert property (p_code) else $error("code mismatch");
	property p_set;
		!unsafe_n |=> unsafe_out;
	endproperty
	a_set: assert property (p_set) else $error("latch not set");
	property p_hold;
		unsafe_out |-> write_select_n && !wcur_en && !wd_drive_en;
	endproperty
	a_hold: assert property (p_hold) else $error("write live under latch");
	property p_pair;
		wd_inv != wd_true;
	endproperty
	a_pair: assert property (p_pair) else $error("pair not complementary");
	property p_clamp;
		!write_select_n |-> read_clamp;
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp off in write");
	property p_gate;
		write_enable_n |=> write_select_n && !wd_drive_en;
	endproperty
	a_gate: assert property (p_gate) else $error("write without gate");
	property p_pulse;
		read_pulse |-> $past(hi_res_cmp, 2) != $past(hi_res_cmp, 3)
			&& $past(lo_res_cmp, 2) == $past(hi_res_cmp, 2);
	endproperty
	a_pulse: assert property (p_pulse) else $error("unqualified pulse");
	// checked through reset itself, so the default disable is overridden
	property p_reset;
		disable iff (1'b0) !resetn |=> write_select_n && !unsafe_out && !wcur_en;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule // wpc_checker
`default_nettype wire

// >>> testbench/preamp_model.sv
// behavioural head preamp: raises unsafe and counts written reversals
`timescale 1ns/1ps
`default_nettype none
module preamp_model (
	input  wire logic   mclk,
	input  wire logic   write_select_n,
	input  wire logic   wd_true,
	input  wire logic   wd_drive_en,
	input  wire logic   wcur_en,
	input  wire logic   fault,
	output logic        unsafe_n,
	output logic [31:0] flux_cnt
);
	logic drv_q = 1'b0;
	logic wd_q = 1'b0;
	// commanded fault, or write current while in read mode
	assign unsafe_n = !(fault || (wcur_en && write_select_n));
	initial flux_cnt = 32'h0;
	// only edges with the driver connected on both sides count
	always @(posedge mclk) begin
		drv_q <= wd_drive_en;
		wd_q <= wd_true;
		if (drv_q && wd_drive_en && wd_q != wd_true)
			flux_cnt <= flux_cnt + 32'h1;
	end
endmodule // preamp_model
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the write path control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import wpc_pkg::*;
	logic              mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
	logic              write_enable_n = 1'b1, wr_bit = 1'b0, wr_bit_valid = 1'b0;
	logic [2:0]        head_sel = 3'h0, head_out;
	logic              unsafe_clear = 1'b0, hi_res_cmp = 1'b0, lo_res_cmp = 1'b0, fault = 1'b0;
	logic              unsafe_n, write_select_n, wd_true, wd_inv, wd_drive_en, wcur_en;
	logic              read_clamp, read_pulse, unsafe_out, rd_d1 = 1'b0, drv_d1 = 1'b0;
	logic [6:0]        wcur_code;
	logic [31:0]       flux_cnt;
	logic [63:0]       note, note_q[$];
	int                err_total = 0, samples_checked = 0;
	always #2 mclk = ~mclk;
	write_path_control #(.RATE_SEL(0)) dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .write_enable_n, .wr_bit, .wr_bit_valid, .head_sel, .unsafe_n,
		.unsafe_clear, .hi_res_cmp, .lo_res_cmp, .write_select_n, .wd_true, .wd_inv,
		.wd_drive_en, .wcur_en, .wcur_code, .head_out, .read_clamp, .read_pulse, .unsafe_out);
	preamp_model preamp (.mclk, .write_select_n, .wd_true, .wd_drive_en, .wcur_en, .fault,
		.unsafe_n, .flux_cnt);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// a read notes mask and expected value; the monitor compares
	task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		note_q.push_back({m, e & m});
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask
	task automatic finish_test();
		err_total += note_q.size();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// read data one cycle after the strobe; flux count when the driver lets go
	always @(posedge mclk) begin
		if (rd_d1) begin
			note = note_q.pop_front();
			chk("reg_rdata", reg_rdata & note[63:32], note[31:0]);
		end else if (drv_d1 && !wd_drive_en && note_q.size() > 0) begin
			note = note_q.pop_front();
			chk("flux_count", flux_cnt, note[31:0]);
		end
		rd_d1 <= reg_rd;
		drv_d1 <= wd_drive_en;
	end
	initial begin
		logic [9:0] cyl;
		logic [7:0] bits;
		logic       lo;
		int         n;
		void'($urandom(4698));
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		rd(REG_STATUS, 32'h7, 32'h0);
		// ends and near-quarter points of the sloped code range, then random cylinders
		for (int i = 0; i < 10; i++) begin
			cyl = (i < 5) ? 10'(i * 'hA6 - i % 2) : 10'($urandom());
			wr(REG_CYL, 32'(cyl));
			rd(REG_WCODE, 32'h7F, (cyl >= 10'h298) ? 32'h0 : 32'(7'h53 - 7'(cyl >> 3)));
		end
		rd(5'h1C, 32'hFFFF_FFFF, 32'h0);
		$display("write current code test done");
		// first and last bit are ones so no boundary flip sits outside the cells
		// head settles a clock before the gate; a later change must not reach the preamp
		head_sel <= 3'h2;
		@(posedge mclk);
		bits = {1'b1, 6'($urandom()), 1'b1};
		n = 0;
		for (int k = 0; k < 8; k++)
			n += int'(bits[k]) + int'(k > 0 && !bits[k - 1] && !bits[k]);
		note_q.push_back({32'hFFFF_FFFF, 32'(n)});
		write_enable_n <= 1'b0;
		// each bit reaches the data flop one clock before its cell starts
		for (int k = 0; k < 8; k++) begin
			wr_bit <= bits[k];
			wr_bit_valid <= 1'b1;
			if (k == 4)
				head_sel <= 3'h5;
			@(posedge mclk);
			wr_bit_valid <= 1'b0;
			repeat (CELL_PS_5M0 / CLK_PERIOD_PS - 1) @(posedge mclk);
		end
		chk("head_out", 32'(head_out), 32'h2);
		write_enable_n <= 1'b1;
		repeat (10) @(posedge mclk);
		rd(REG_WRCNT, 32'hFFFF, 32'h8);
		$display("cell encoder test done");
		wr(REG_CTRL, 32'h2);
		write_enable_n <= 1'b0;
		rd(REG_STATUS, 32'h6, 32'h0);
		write_enable_n <= 1'b1;
		wr(REG_CTRL, 32'h0);
		// fault in mid write, a clear colliding with a fault, then real clears
		write_enable_n <= 1'b0;
		repeat (10) @(posedge mclk);
		fault <= 1'b1;
		repeat (2) @(posedge mclk);
		fault <= 1'b0;
		rd(REG_STATUS, 32'h7, 32'h1);
		fault <= 1'b1;
		unsafe_clear <= 1'b1;
		@(posedge mclk);
		fault <= 1'b0;
		unsafe_clear <= 1'b0;
		rd(REG_STATUS, 32'h1, 32'h1);
		write_enable_n <= 1'b1;
		unsafe_clear <= 1'b1;
		@(posedge mclk);
		unsafe_clear <= 1'b0;
		rd(REG_STATUS, 32'h1, 32'h0);
		fault <= 1'b1;
		@(posedge mclk);
		fault <= 1'b0;
		wr(REG_CTRL, 32'h1);
		rd(REG_STATUS, 32'h1, 32'h0);
		$display("unsafe latch test done");
		// comparator edges, the first nine under the write clamp
		write_enable_n <= 1'b0;
		n = 0;
		for (int s = 0; s < 40; s++) begin
			repeat (4) @(posedge mclk);
			lo = 1'($urandom());
			n += int'(s > 8 && lo == !hi_res_cmp);
			if (s == 8)
				write_enable_n <= 1'b1;
			hi_res_cmp <= !hi_res_cmp;
			lo_res_cmp <= lo;
		end
		repeat (4) @(posedge mclk);
		rd(REG_RDCNT, 32'hFFFF, 32'(n));
		$display("read qualifier test done");
		// let the monitor take the last read note
		repeat (2) @(posedge mclk);
		finish_test();
	end
	// the tests need about seven hundred cycles; this allows fifty thousand
	initial begin
		#200000;
		err_total++;
		finish_test();
	end
endmodule // testbench
bind write_path_control wpc_checker chk_i (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
	.write_enable_n, .unsafe_n, .hi_res_cmp, .lo_res_cmp, .write_select_n, .wd_true, .wd_inv,
	.wd_drive_en, .wcur_en, .wcur_code, .read_clamp, .read_pulse, .unsafe_out);
`default_nettype wire
